// *** include/fgm_pkg.sv ***
// Shared constants, types and the CRC step function of the forty-gig MAC datapath.
package fgm_pkg;

  // ******************************
  // Port geometry
  // ******************************
  localparam int CLIENT_W = 128;       // Custom streaming client word.
  localparam int CLIENT_BYTES = 16;
  localparam int EMPTY_W = 4;
  localparam int PHY_LANES = 4;        // Serial lanes of the attachment unit.
  localparam int LANE_W = 2;
  localparam real LANE_GBPS = 10.3125; // Line rate of each lane.
  localparam int MGMT_DATA_W = 32;     // Management slave data width.
  localparam int MGMT_ADDR_W = 16;     // Management slave address width.
  localparam int RECONF_DATA_W = 32;   // Transceiver reconfiguration data width.
  localparam int RECONF_ADDR_W = 12;   // Transceiver reconfiguration address width.
  localparam int STAT_W = 32;
  localparam int CRC_CTRL_W = 2;
  localparam int CRC_PASS_BIT = 1;     // Receive CRC pass-through bit of the CRC control word.

  // ******************************
  // Line characters and framing figures
  // ******************************
  localparam logic [7:0] XG_IDLE = 8'h07;
  localparam logic [7:0] XG_START = 8'hfb;
  localparam logic [7:0] XG_TERM = 8'hfd;
  localparam logic [7:0] XG_ERROR = 8'hfe;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [15:0] PRE_LEN = 16'h0008;
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] CRC_LEN = 16'h0004;
  localparam logic [15:0] PAD_TARGET = MIN_FRAME - CRC_LEN;
  localparam logic [15:0] PAD_FLOOR = 16'h0008;
  localparam logic [3:0] IPG_BYTES = 4'hc;
  localparam logic [2:0] RX_HOLD = 3'h5;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // ******************************
  // State types
  // ******************************
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_DATA, T_PAD, T_CRC, T_TERM, T_IPG} fgm_tx_state_type;
  typedef enum logic [1:0] {R_IDLE, R_PRE, R_DATA, R_FLUSH} fgm_rx_state_type;

  // One byte of the reflected Ethernet CRC, least significant bit first.
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b);
    logic [31:0] c;
    c = crc ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// *** hw/fgm_fifo.sv ***
// Word FIFO with valid and ready on both sides, held in flip-flops.
`timescale 1ns/1ps
module fgm_fifo #(
  parameter int WIDTH = 134,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic push, pop;

  // ******************************
  // Pointer and count update
  // ******************************
  // Ready is registered so that the client never sees a combinational path into the MAC.
  always_comb begin
    push = in_valid_i & ready_reg;
    pop = out_ready_i & (cnt_reg != '0);
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_i;
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    ready_next = (cnt_next != CW'(DEPTH));
  end

  // Registers only.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
    mem_reg <= mem_next;
  end

  assign in_ready_o = ready_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
endmodule // fgm_fifo

// *** hw/fgm_mac.sv ***
// Forty-gig Ethernet MAC datapath: transmit framing and receive checking.
`timescale 1ns/1ps
// Operation
// - Transmit adds gap and CRC to each client frame, preamble and delimiter unless pass-through, and padding to short ones.
// - Receive checks frames, counts them, strips CRC and preamble unless passed through, delivers the rest.
// - Receive preamble pass-through forwards preamble and delimiter to the client.
// - CRC control bit 1 set keeps received CRC bytes in the client data.
// - With CRC pass-through, end-of-packet comes with the last CRC byte.
// - Client data path is a 128-bit custom stream.
// - Management slave port has 32-bit data and 16-bit address.
// - Line side uses four serial lanes at 10.3125 Gbps each.
// - Optional reconfiguration port has 32-bit data and 12-bit address.
// - Frames between nine and 59 bytes are padded with zeros to 60, 64 with the CRC.
// - Eight-byte preamble starting with 0xFB is prefixed unless pass-through.
module fgm_mac #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tx_pre_pass_i,
  input wire logic rx_pre_pass_i,
  input wire logic [fgm_pkg::CRC_CTRL_W-1:0] crc_ctrl_i,
  input wire logic [fgm_pkg::CLIENT_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  input wire logic [fgm_pkg::EMPTY_W-1:0] tx_empty_i,
  output logic tx_ready_o,
  output logic [7:0] phy_tx_data_o,
  output logic phy_tx_ctrl_o,
  output logic [fgm_pkg::LANE_W-1:0] phy_tx_lane_o,
  input wire logic [7:0] phy_rx_data_i,
  input wire logic phy_rx_ctrl_i,
  output logic [fgm_pkg::CLIENT_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_sop_o,
  output logic rx_eop_o,
  output logic [fgm_pkg::EMPTY_W-1:0] rx_empty_o,
  output logic rx_error_o,
  output logic [fgm_pkg::STAT_W-1:0] tx_frames_o,
  output logic [fgm_pkg::STAT_W-1:0] rx_good_o,
  output logic [fgm_pkg::STAT_W-1:0] rx_bad_o
);
  localparam int FW = fgm_pkg::CLIENT_W + 2 + fgm_pkg::EMPTY_W;

  // ******************************
  // Mode pin synchronisers
  // ******************************
  // Mode pins are quasi-static; each passes two flops before any logic uses it.
  logic [2:0] mode_s1_reg, mode_s2_reg;
  logic tx_pass_pin, rx_pass_pin, crc_pass_pin;

  always_ff @(posedge sys_clk_i) begin
    mode_s1_reg <= {crc_ctrl_i[fgm_pkg::CRC_PASS_BIT], rx_pre_pass_i, tx_pre_pass_i};
    mode_s2_reg <= mode_s1_reg;
  end

  assign tx_pass_pin = mode_s2_reg[0];
  assign rx_pass_pin = mode_s2_reg[1];
  assign crc_pass_pin = mode_s2_reg[2];

  // ******************************
  // Transmit FIFO
  // ******************************
  logic [FW-1:0] ff_word;
  logic ff_valid, ff_pop;
  logic [fgm_pkg::CLIENT_W-1:0] ff_data;
  logic ff_sop, ff_eop;
  logic [fgm_pkg::EMPTY_W-1:0] ff_empty;

  fgm_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i({tx_data_i, tx_sop_i, tx_eop_i, tx_empty_i}),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(ff_word),
    .out_valid_o(ff_valid),
    .out_ready_i(ff_pop)
  );

  assign {ff_data, ff_sop, ff_eop, ff_empty} = ff_word;

  // ******************************
  // Transmit framer
  // ******************************
  fgm_pkg::fgm_tx_state_type ts_reg, ts_next;
  logic [3:0] idx_reg, idx_next, tcnt_reg, tcnt_next;
  logic [15:0] pos_reg, pos_next, hdr_reg, hdr_next;
  logic [31:0] tcrc_reg, tcrc_next;
  logic [7:0] td_reg, td_next;
  logic tc_reg, tc_next;
  logic [fgm_pkg::LANE_W-1:0] tl_reg, tl_next;
  logic [fgm_pkg::STAT_W-1:0] txf_reg, txf_next;
  logic [15:0] flen;
  logic [7:0] cur;
  logic last_in_word;

  // Byte-serial framer; line bytes are dealt to the four lanes in turn.
  always_comb begin
    ts_next = ts_reg;
    idx_next = idx_reg;
    tcnt_next = tcnt_reg;
    pos_next = pos_reg;
    hdr_next = hdr_reg;
    tcrc_next = tcrc_reg;
    txf_next = txf_reg;
    td_next = fgm_pkg::XG_IDLE;
    tc_next = 1'b1;
    tl_next = tl_reg + 1'b1;
    ff_pop = 1'b0;
    flen = pos_reg + 16'h0001 - hdr_reg;
    cur = ff_data[8*(fgm_pkg::CLIENT_BYTES-1-int'(idx_reg)) +: 8];
    last_in_word = ff_eop ? (idx_reg == 4'hf - ff_empty) : (idx_reg == 4'hf);
    unique case (ts_reg)
      fgm_pkg::T_IDLE: begin
        // A stray word without start of packet is discarded rather than framed.
        if (ff_valid && !ff_sop) begin
          ff_pop = 1'b1;
        end else if (ff_valid) begin
          pos_next = '0;
          idx_next = '0;
          tcnt_next = '0;
          tcrc_next = fgm_pkg::CRC_INIT;
          hdr_next = tx_pass_pin ? fgm_pkg::PRE_LEN : 16'h0000;
          ts_next = tx_pass_pin ? fgm_pkg::T_DATA : fgm_pkg::T_PRE;
        end
      end
      fgm_pkg::T_PRE: begin
        tc_next = (tcnt_reg == 4'h0);
        td_next = (tcnt_reg == 4'h0) ? fgm_pkg::XG_START :
                  (tcnt_reg == 4'h7) ? fgm_pkg::SFD_BYTE : fgm_pkg::PRE_BYTE;
        tcnt_next = tcnt_reg + 1'b1;
        if (tcnt_reg == 4'h7) begin
          ts_next = fgm_pkg::T_DATA;
        end
      end
      fgm_pkg::T_DATA: begin
        // An underrun cannot be hidden on the line, so the frame is marked bad.
        if (!ff_valid) begin
          td_next = fgm_pkg::XG_ERROR;
        end else begin
          td_next = cur;
          tc_next = (pos_reg == 16'h0000) && (hdr_reg != 16'h0000);
          if (pos_reg >= hdr_reg) begin
            tcrc_next = fgm_pkg::crc_byte(tcrc_reg, cur);
          end
          pos_next = pos_reg + 16'h0001;
          idx_next = idx_reg + 1'b1;
          if (last_in_word) begin
            ff_pop = 1'b1;
            idx_next = '0;
            if (ff_eop) begin
              tcnt_next = '0;
              if (flen < fgm_pkg::PAD_TARGET && flen > fgm_pkg::PAD_FLOOR) begin
                ts_next = fgm_pkg::T_PAD;
              end else begin
                ts_next = fgm_pkg::T_CRC;
              end
            end
          end
        end
      end
      fgm_pkg::T_PAD: begin
        td_next = fgm_pkg::PAD_BYTE;
        tc_next = 1'b0;
        tcrc_next = fgm_pkg::crc_byte(tcrc_reg, fgm_pkg::PAD_BYTE);
        pos_next = pos_reg + 16'h0001;
        if (flen == fgm_pkg::PAD_TARGET) begin
          ts_next = fgm_pkg::T_CRC;
        end
      end
      fgm_pkg::T_CRC: begin
        td_next = ~tcrc_reg[8*int'(tcnt_reg[1:0]) +: 8];
        tc_next = 1'b0;
        tcnt_next = tcnt_reg + 1'b1;
        if (tcnt_reg == 4'h3) begin
          ts_next = fgm_pkg::T_TERM;
        end
      end
      fgm_pkg::T_TERM: begin
        td_next = fgm_pkg::XG_TERM;
        txf_next = txf_reg + 1'b1;
        tcnt_next = '0;
        ts_next = fgm_pkg::T_IPG;
      end
      fgm_pkg::T_IPG: begin
        tcnt_next = tcnt_reg + 1'b1;
        if (tcnt_reg == fgm_pkg::IPG_BYTES - 4'h1) begin
          ts_next = fgm_pkg::T_IDLE;
        end
      end
    endcase
  end

  // Registers only; reset leaves the line idle and the count cleared.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ts_reg <= fgm_pkg::T_IDLE;
      idx_reg <= '0;
      tcnt_reg <= '0;
      pos_reg <= '0;
      hdr_reg <= '0;
      tcrc_reg <= fgm_pkg::CRC_INIT;
      td_reg <= fgm_pkg::XG_IDLE;
      tc_reg <= 1'b1;
      tl_reg <= '0;
      txf_reg <= '0;
    end else begin
      ts_reg <= ts_next;
      idx_reg <= idx_next;
      tcnt_reg <= tcnt_next;
      pos_reg <= pos_next;
      hdr_reg <= hdr_next;
      tcrc_reg <= tcrc_next;
      td_reg <= td_next;
      tc_reg <= tc_next;
      tl_reg <= tl_next;
      txf_reg <= txf_next;
    end
  end

  assign phy_tx_data_o = td_reg;
  assign phy_tx_ctrl_o = tc_reg;
  assign phy_tx_lane_o = tl_reg;
  assign tx_frames_o = txf_reg;

  // ******************************
  // Receive checker and assembler
  // ******************************
  fgm_pkg::fgm_rx_state_type rs_reg, rs_next;
  logic [7:0] del_reg [5];
  logic [7:0] del_next [5];
  logic [2:0] dcnt_reg, dcnt_next, fcnt_reg, fcnt_next, rcnt_reg, rcnt_next;
  logic [15:0] rlen_reg, rlen_next;
  logic [31:0] rcrc_reg, rcrc_next;
  logic rerr_reg, rerr_next, good_reg, good_next, rpass_reg, rpass_next;
  logic cpass_reg, cpass_next, sopp_reg, sopp_next;
  logic [fgm_pkg::CLIENT_W-1:0] asm_reg, asm_next, word;
  logic [3:0] acnt_reg, acnt_next;
  logic [fgm_pkg::CLIENT_W-1:0] rd_reg, rd_next;
  logic rv_reg, rv_next, rsop_reg, rsop_next, reop_reg, reop_next, rerr_o_reg, rerr_o_next;
  logic [fgm_pkg::EMPTY_W-1:0] remp_reg, remp_next;
  logic [fgm_pkg::STAT_W-1:0] rgood_reg, rgood_next, rbad_reg, rbad_next;
  logic shift_in, push, push_last;
  logic [7:0] push_byte;
  logic [2:0] keep;

  // A five-byte hold line delays data so the trailing CRC is known before it leaves.
  always_comb begin
    rs_next = rs_reg;
    del_next = del_reg;
    dcnt_next = dcnt_reg;
    fcnt_next = fcnt_reg;
    rcnt_next = rcnt_reg;
    rlen_next = rlen_reg;
    rcrc_next = rcrc_reg;
    rerr_next = rerr_reg;
    good_next = good_reg;
    rpass_next = rpass_reg;
    cpass_next = cpass_reg;
    rgood_next = rgood_reg;
    rbad_next = rbad_reg;
    shift_in = 1'b0;
    push = 1'b0;
    push_last = 1'b0;
    push_byte = del_reg[4];
    keep = cpass_reg ? dcnt_reg : dcnt_reg - 3'h4;
    unique case (rs_reg)
      fgm_pkg::R_IDLE: begin
        if (phy_rx_ctrl_i && phy_rx_data_i == fgm_pkg::XG_START) begin
          rpass_next = rx_pass_pin;
          cpass_next = crc_pass_pin;
          shift_in = rx_pass_pin;
          rcnt_next = 3'h1;
          rlen_next = '0;
          rcrc_next = fgm_pkg::CRC_INIT;
          rerr_next = 1'b0;
          rs_next = fgm_pkg::R_PRE;
        end
      end
      fgm_pkg::R_PRE: begin
        // A control character inside the preamble aborts the frame silently.
        if (phy_rx_ctrl_i) begin
          dcnt_next = '0;
          rs_next = fgm_pkg::R_IDLE;
        end else begin
          shift_in = rpass_reg;
          rcnt_next = rcnt_reg + 1'b1;
          if (rcnt_reg == 3'h7) begin
            rs_next = fgm_pkg::R_DATA;
          end
        end
      end
      fgm_pkg::R_DATA: begin
        if (phy_rx_ctrl_i && phy_rx_data_i == fgm_pkg::XG_TERM) begin
          good_next = (rcrc_reg == fgm_pkg::CRC_RESIDUE) && !rerr_reg &&
                      (rlen_reg >= fgm_pkg::MIN_FRAME);
          rgood_next = rgood_reg + (good_next ? 1'b1 : 1'b0);
          rbad_next = rbad_reg + (good_next ? 1'b0 : 1'b1);
          fcnt_next = keep;
          rs_next = (keep == 3'h0 || dcnt_reg < 3'h4) ? fgm_pkg::R_IDLE : fgm_pkg::R_FLUSH;
          if (keep == 3'h0 || dcnt_reg < 3'h4) begin
            dcnt_next = '0;
          end
        end else if (phy_rx_ctrl_i) begin
          rerr_next = 1'b1;
        end else begin
          shift_in = 1'b1;
          rlen_next = rlen_reg + 16'h0001;
          rcrc_next = fgm_pkg::crc_byte(rcrc_reg, phy_rx_data_i);
        end
      end
      fgm_pkg::R_FLUSH: begin
        push = 1'b1;
        push_byte = del_reg[dcnt_reg - 3'h1];
        push_last = (fcnt_reg == 3'h1);
        fcnt_next = fcnt_reg - 3'h1;
        dcnt_next = dcnt_reg - 3'h1;
        if (fcnt_reg == 3'h1) begin
          dcnt_next = '0;
          rs_next = fgm_pkg::R_IDLE;
        end
      end
    endcase
    if (shift_in) begin
      push = (dcnt_reg == fgm_pkg::RX_HOLD);
      del_next[0] = phy_rx_data_i;
      for (int i = 1; i < 5; i++) begin
        del_next[i] = del_reg[i-1];
      end
      if (dcnt_reg != fgm_pkg::RX_HOLD) begin
        dcnt_next = dcnt_reg + 3'h1;
      end
    end
  end

  // Bytes pack from the top lane down; a word leaves when full or at end of packet.
  always_comb begin
    asm_next = asm_reg;
    acnt_next = acnt_reg;
    sopp_next = sopp_reg;
    rd_next = rd_reg;
    rv_next = 1'b0;
    rsop_next = 1'b0;
    reop_next = 1'b0;
    remp_next = '0;
    rerr_o_next = 1'b0;
    word = asm_reg;
    word[8*(fgm_pkg::CLIENT_BYTES-1-int'(acnt_reg)) +: 8] = push_byte;
    if (rs_reg == fgm_pkg::R_IDLE && rs_next == fgm_pkg::R_PRE) begin
      sopp_next = 1'b1;
    end
    if (rs_reg == fgm_pkg::R_DATA && rs_next == fgm_pkg::R_IDLE) begin
      acnt_next = '0; // Runt with nothing left to flush: drop the partial word.
    end
    if (push) begin
      asm_next = word;
      acnt_next = acnt_reg + 1'b1;
      if (acnt_reg == 4'hf || push_last) begin
        rd_next = word;
        rv_next = 1'b1;
        rsop_next = sopp_reg;
        reop_next = push_last;
        remp_next = 4'hf - acnt_reg;
        rerr_o_next = push_last & ~good_reg;
        sopp_next = 1'b0;
        asm_next = '0;
        acnt_next = '0;
      end
    end
  end

  // Registers only; reset clears the receive outputs and the counts.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rs_reg <= fgm_pkg::R_IDLE;
      dcnt_reg <= '0;
      fcnt_reg <= '0;
      rcnt_reg <= '0;
      rlen_reg <= '0;
      rcrc_reg <= fgm_pkg::CRC_INIT;
      rerr_reg <= 1'b0;
      good_reg <= 1'b0;
      rpass_reg <= 1'b0;
      cpass_reg <= 1'b0;
      sopp_reg <= 1'b0;
      asm_reg <= '0;
      acnt_reg <= '0;
      rd_reg <= '0;
      rv_reg <= 1'b0;
      rsop_reg <= 1'b0;
      reop_reg <= 1'b0;
      remp_reg <= '0;
      rerr_o_reg <= 1'b0;
      rgood_reg <= '0;
      rbad_reg <= '0;
    end else begin
      rs_reg <= rs_next;
      dcnt_reg <= dcnt_next;
      fcnt_reg <= fcnt_next;
      rcnt_reg <= rcnt_next;
      rlen_reg <= rlen_next;
      rcrc_reg <= rcrc_next;
      rerr_reg <= rerr_next;
      good_reg <= good_next;
      rpass_reg <= rpass_next;
      cpass_reg <= cpass_next;
      sopp_reg <= sopp_next;
      asm_reg <= asm_next;
      acnt_reg <= acnt_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      rsop_reg <= rsop_next;
      reop_reg <= reop_next;
      remp_reg <= remp_next;
      rerr_o_reg <= rerr_o_next;
      rgood_reg <= rgood_next;
      rbad_reg <= rbad_next;
    end
    del_reg <= del_next;
  end

  assign rx_data_o = rd_reg;
  assign rx_valid_o = rv_reg;
  assign rx_sop_o = rsop_reg;
  assign rx_eop_o = reop_reg;
  assign rx_empty_o = remp_reg;
  assign rx_error_o = rerr_o_reg;
  assign rx_good_o = rgood_reg;
  assign rx_bad_o = rbad_reg;
endmodule // fgm_mac

// *** tb/fgm_mac_sva.sv ***
// Concurrent checks on the ports of the MAC datapath.
`timescale 1ns/1ps
module fgm_mac_sva (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tx_pre_pass_i,
  input wire logic tx_ready_o,
  input wire logic [7:0] phy_tx_data_o,
  input wire logic phy_tx_ctrl_o,
  input wire logic [fgm_pkg::LANE_W-1:0] phy_tx_lane_o,
  input wire logic rx_valid_o,
  input wire logic rx_sop_o,
  input wire logic rx_eop_o,
  input wire logic [fgm_pkg::STAT_W-1:0] tx_frames_o,
  input wire logic [fgm_pkg::STAT_W-1:0] rx_good_o,
  input wire logic [fgm_pkg::STAT_W-1:0] rx_bad_o
);
  // One clock domain, so clocking and the reset guard are shared.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_line_idle: assert property (disable iff (1'b0) sys_rst_i |=> phy_tx_ctrl_o &&
    phy_tx_data_o == fgm_pkg::XG_IDLE && phy_tx_lane_o == 2'h0 && !tx_ready_o)
    else $error("line not idle after reset");
  a_reset_stats: assert property (disable iff (1'b0) sys_rst_i |=> tx_frames_o == 32'h0 &&
    rx_good_o == 32'h0 && rx_bad_o == 32'h0 && !rx_valid_o)
    else $error("counters or receive output not cleared by reset");
  a_lane_round_robin: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    phy_tx_lane_o == $past(phy_tx_lane_o) + 2'h1)
    else $error("lane index did not advance");
  a_preamble_run: assert property (phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::XG_START &&
    !tx_pre_pass_i |=> (!phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::PRE_BYTE) [*6] ##1
    (!phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::SFD_BYTE))
    else $error("preamble after start byte is wrong");
  a_gap_after_term: assert property (phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::XG_TERM |=>
    (phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::XG_IDLE) [*8] ##1
    (phy_tx_ctrl_o && phy_tx_data_o == fgm_pkg::XG_IDLE) [*4])
    else $error("gap after terminate too short");
  a_rx_word_pulse: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive valid held longer than one cycle");
  a_marks_with_valid: assert property (rx_sop_o || rx_eop_o |-> rx_valid_o)
    else $error("packet mark without valid");
  a_one_verdict: assert property ($changed(rx_good_o) |-> $stable(rx_bad_o) &&
    rx_good_o == $past(rx_good_o) + 32'h1)
    else $error("good frame count stepped wrongly");
  a_bad_step: assert property ($changed(rx_bad_o) |-> rx_bad_o == $past(rx_bad_o) + 32'h1)
    else $error("bad frame count stepped wrongly");
  a_tx_count_step: assert property ($changed(tx_frames_o) |->
    tx_frames_o == $past(tx_frames_o) + 32'h1)
    else $error("sent frame count stepped wrongly");
endmodule // fgm_mac_sva

bind fgm_mac fgm_mac_sva fgm_mac_sva_inst (.sys_clk_i, .sys_rst_i, .tx_pre_pass_i, .tx_ready_o,
  .phy_tx_data_o, .phy_tx_ctrl_o, .phy_tx_lane_o, .rx_valid_o, .rx_sop_o, .rx_eop_o,
  .tx_frames_o, .rx_good_o, .rx_bad_o);

// *** tb/fgm_phy_loop.sv ***
// Loopback line model standing in for the four-lane PHY.
`timescale 1ns/1ps
module fgm_phy_loop (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic corrupt_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_ctrl_i,
  output logic [7:0] rx_data_o,
  output logic rx_ctrl_o
);
  // Each line byte returns one cycle later; corruption flips the low bit of each data byte so the CRC fails.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_data_o <= fgm_pkg::XG_IDLE;
      rx_ctrl_o <= 1'b1;
    end else begin
      rx_data_o <= tx_data_i ^ {7'h00, corrupt_i & ~tx_ctrl_i};
      rx_ctrl_o <= tx_ctrl_i;
    end
  end
endmodule // fgm_phy_loop

// *** tb/test_fgm_mac.sv ***
// Self-checking bench for the MAC datapath run in line loopback.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, sn); end end
module test_fgm_mac;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tx_pre_pass_i = 1'b0;
  logic rx_pre_pass_i = 1'b0;
  logic [fgm_pkg::CRC_CTRL_W-1:0] crc_ctrl_i = 2'h0;
  logic [127:0] tx_data_i = '0;
  logic tx_valid_i = 1'b0;
  logic tx_sop_i = 1'b0;
  logic tx_eop_i = 1'b0;
  logic [3:0] tx_empty_i = 4'h0;
  logic corrupt = 1'b0;
  logic tx_ready_o, phy_tx_ctrl_o, phy_rx_ctrl_i, rx_valid_o, rx_sop_o, rx_eop_o, rx_error_o;
  logic [7:0] phy_tx_data_o, phy_rx_data_i;
  logic [1:0] phy_tx_lane_o;
  logic [127:0] rx_data_o;
  logic [3:0] rx_empty_o;
  logic [31:0] tx_frames_o, rx_good_o, rx_bad_o;
  logic [7:0] rx_q[$];
  logic rx_done, rx_err, saw_full, rx_sop1;
  int compares = 0, miscompares = 0, line_cnt = 0, line_len = 0, exp_good, exp_bad, exp_tx;

  fgm_mac fgm_mac_inst (.sys_clk_i, .sys_rst_i, .tx_pre_pass_i, .rx_pre_pass_i, .crc_ctrl_i,
    .tx_data_i, .tx_valid_i, .tx_sop_i, .tx_eop_i, .tx_empty_i, .tx_ready_o, .phy_tx_data_o,
    .phy_tx_ctrl_o, .phy_tx_lane_o, .phy_rx_data_i, .phy_rx_ctrl_i, .rx_data_o, .rx_valid_o,
    .rx_sop_o, .rx_eop_o, .rx_empty_o, .rx_error_o, .tx_frames_o, .rx_good_o, .rx_bad_o);
  fgm_phy_loop fgm_phy_loop_inst (.sys_clk_i, .sys_rst_i, .corrupt_i(corrupt),
    .tx_data_i(phy_tx_data_o), .tx_ctrl_i(phy_tx_ctrl_o), .rx_data_o(phy_rx_data_i),
    .rx_ctrl_o(phy_rx_ctrl_i));

  // The clock runs from time zero; reset is applied from the start.
  always #5 sys_clk_i = ~sys_clk_i;

  // Collect delivered bytes and count line bytes after the delimiter, sampled mid-cycle.
  always @(negedge sys_clk_i) begin
    if (rx_valid_o === 1'b1) begin
      if (rx_q.size() == 0) rx_sop1 = rx_sop_o;
      for (int b = 0; b < 16 - (rx_eop_o ? int'(rx_empty_o) : 0); b++) begin
        rx_q.push_back(rx_data_o[127-8*b -: 8]);
      end
      if (rx_eop_o === 1'b1) begin
        rx_done = 1'b1;
        rx_err = rx_error_o;
      end
    end
    if (phy_tx_ctrl_o === 1'b1 && phy_tx_data_o === fgm_pkg::XG_START) line_cnt = -7;
    else if (phy_tx_ctrl_o === 1'b0) line_cnt++;
    if (phy_tx_ctrl_o === 1'b1 && phy_tx_data_o === fgm_pkg::XG_TERM) line_len = line_cnt;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Offer n client bytes, stopping after stop words; a late ready marks the FIFO as full.
  task automatic send(input int n, input int stop);
    int w;
    int k;
    for (w = 0; w * 16 < n && w < stop; w++) begin
      for (k = 0; k < 16; k++) tx_data_i[127-8*k -: 8] = pat(w * 16 + k);
      // With transmit pass-through the client owns the eight preamble bytes.
      if (w == 0 && tx_pre_pass_i) tx_data_i[127 -: 64] =
        {fgm_pkg::XG_START, {6{fgm_pkg::PRE_BYTE}}, fgm_pkg::SFD_BYTE};
      tx_sop_i = (w == 0);
      tx_eop_i = ((w + 1) * 16 >= n);
      tx_empty_i = tx_eop_i ? 4'((w + 1) * 16 - n) : 4'h0;
      tx_valid_i = 1'b1;
      for (k = 0; k < 300 && tx_ready_o !== 1'b1; k++) begin
        saw_full = 1'b1;
        @(negedge sys_clk_i);
      end
      if (k == 300) begin
        miscompares++;
        give_verdict();
      end
      @(negedge sys_clk_i);
    end
    tx_valid_i = 1'b0;
  endtask

  task automatic do_reset;
    sys_rst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    exp_good = 0;
    exp_bad = 0;
    exp_tx = 0;
  endtask

  // One frame through the loop, judged on the line and at the client side.
  task automatic run_frame(input int n, input logic cp, input logic pp, input logic bad);
    int k;
    int pay;
    int off;
    crc_ctrl_i = {cp, 1'b0};
    rx_pre_pass_i = pp;
    corrupt = bad;
    off = tx_pre_pass_i ? 8 : 0;
    repeat (4) @(negedge sys_clk_i);
    rx_q.delete();
    rx_done = 1'b0;
    rx_sop1 = 1'b0;
    send(n, 99);
    for (k = 0; k < 800 && rx_done !== 1'b1; k++) @(negedge sys_clk_i);
    if (k == 800) begin
      miscompares++;
      give_verdict();
    end
    pay = (n - off < 60) ? 60 : n - off;
    `CHK("line_bytes", pay + 4, line_len)
    `CHK("rx_error", bad, rx_err)
    `CHK("rx_sop", 1'b1, rx_sop1)
    if (!bad) begin
      `CHK("rx_count", pay + (cp ? 4 : 0) + (pp ? 8 : 0), rx_q.size())
      for (k = 0; k < pay; k++) begin
        `CHK("rx_byte", (k < n - off) ? pat(k + off) : fgm_pkg::PAD_BYTE, rx_q[k + 8 * pp])
      end
      if (pp) `CHK("rx_sfd", fgm_pkg::SFD_BYTE, rx_q[7])
    end
    if (bad) exp_bad++;
    else exp_good++;
    exp_tx++;
    `CHK("rx_good", 32'(exp_good), rx_good_o)
    `CHK("rx_bad", 32'(exp_bad), rx_bad_o)
    `CHK("tx_frames", 32'(exp_tx), tx_frames_o)
  endtask

  task automatic t_lengths;
    run_frame(9, 1'b0, 1'b0, 1'b0);
    run_frame(20, 1'b0, 1'b0, 1'b0);
    run_frame(60, 1'b0, 1'b0, 1'b0);
    run_frame(61, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_pass_modes;
    run_frame(33, 1'b1, 1'b0, 1'b0);
    run_frame(40, 1'b0, 1'b1, 1'b0);
    run_frame(70, 1'b1, 1'b1, 1'b0);
    tx_pre_pass_i = 1'b1;
    run_frame(40, 1'b0, 1'b1, 1'b0);
    tx_pre_pass_i = 1'b0;
  endtask

  task automatic t_bad_crc;
    run_frame(64, 1'b0, 1'b0, 1'b1);
    run_frame(64, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_fifo_full;
    saw_full = 1'b0;
    run_frame(192, 1'b0, 1'b0, 1'b0);
    `CHK("fifo_refused", 1'b1, saw_full)
  endtask

  // Reset lands in mid-frame; outputs must be idle and the sent and good-frame counts cleared, then framing resumes.
  task automatic t_reset_mid;
    send(64, 2);
    repeat (3) @(negedge sys_clk_i);
    do_reset();
    `CHK("line_idle", fgm_pkg::XG_IDLE, phy_tx_data_o)
    `CHK("ready_low", 1'b0, tx_ready_o)
    `CHK("tx_frames_clr", 32'h0, tx_frames_o)
    `CHK("rx_good_clr", 32'h0, rx_good_o)
    run_frame(16, 1'b0, 1'b0, 1'b0);
  endtask

  initial begin
    do_reset();
    t_lengths();
    t_pass_modes();
    t_bad_crc();
    t_fifo_full();
    t_reset_mid();
    give_verdict();
  end
endmodule // test_fgm_mac
